// [core/spib_pkg.sv]
/*
  Constants, register map and types of the serial port with its
  interrupt requests and baud generator. Assumes APB with 32-bit data.
*/
package spib_pkg;
  localparam int          ADDR_W     = 17;
  localparam logic [14:0] IDX_CCR    = 15'h7050;
  localparam logic [14:0] IDX_CTL1   = 15'h7051;
  localparam logic [14:0] IDX_HBAUD  = 15'h7052;
  localparam logic [14:0] IDX_LBAUD  = 15'h7053;
  localparam logic [14:0] IDX_CTL2   = 15'h7054;
  localparam logic [14:0] IDX_RXST   = 15'h7055;
  localparam logic [14:0] IDX_RXEMU  = 15'h7056;
  localparam logic [14:0] IDX_RXBUF  = 15'h7057;
  localparam logic [14:0] IDX_TXBUF  = 15'h7059;
  localparam logic [14:0] IDX_PC2    = 15'h705e;
  localparam logic [14:0] IDX_PRI    = 15'h705f;
  localparam int          CCR_STOP2  = 7;
  localparam int          CCR_EVEN   = 6;
  localparam int          CCR_PAREN  = 5;
  localparam int          CTL1_SRSTN = 5;
  localparam int          CTL1_TXENA = 1;
  localparam int          CTL1_RXENA = 0;
  localparam int          CTL1_TXWK  = 3;
  localparam int          CTL2_TRANSMIT_READY_FLAG = 7;
  localparam int          CTL2_EMPTY = 6;
  localparam int          CTL2_RXIE  = 1;
  localparam int          CTL2_TXIE  = 0;
  localparam int          PRI_TX     = 6;
  localparam int          PRI_RX     = 5;
  localparam logic [7:0]  PRI_MASK   = 8'h70;
  localparam logic [7:0]  CTL1_MASK  = 8'h7f;
  localparam logic [7:0]  RST_REG    = 8'h00;
  localparam int          TICKS_BIT  = 8;
  localparam int          ZERO_DIV   = 16;
  localparam logic [15:0] ZERO_LIM   = 16'(ZERO_DIV / TICKS_BIT - 1);
  localparam int          START_TK   = 4;
  localparam int          BREAK_BITS = 10;
  localparam logic [6:0]  BREAK_LIM  = 7'(BREAK_BITS * TICKS_BIT - 1);
  localparam logic [2:0]  SAMP_A     = 3'h3;
  localparam logic [2:0]  SAMP_B     = 3'h4;
  localparam logic [2:0]  SAMP_C     = 3'h5;
  localparam logic [2:0]  TICK_LAST  = 3'(TICKS_BIT - 1);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} spib_rx_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} spib_tx_t;
endpackage

// [core/spib_top.sv]
/*
  Serial port with receive FIFO, baud generator, flags, interrupt requests
  and the APB register file. Assumes rxd is synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module spib_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clr,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  initial begin
    if (D < 2 || (1 << AW) != D) $error("fifo depth must be a power of two");
  end
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } spib_fifo_t;
  spib_fifo_t s_r;
  spib_fifo_t s_nxt;
  logic push;
  logic pop;
  assign in_ready  = (s_r.wp - s_r.rp) != (AW+1)'(D);
  assign out_valid = s_r.wp != s_r.rp;
  assign out_data  = s_r.mem[s_r.rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (clr) begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module spib_top (
  // Clock and reset.
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  // APB slave.
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [spib_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Serial line.
  input  wire logic                       rxd,
  output logic                            txd,
  // Interrupt requests.
  output logic                            rx_irq_req,
  output logic                            tx_irq_req,
  output logic                            irq_level_hi,
  output logic                            irq_hi_is_tx,
  output logic                            irq_level_lo,
  output logic                            irq_lo_is_tx
);
  import spib_pkg::*;
  typedef struct packed {
    logic [7:0]  ccr, ctl1, hbaud, lbaud, pc2, pri, rxbuf, txbuf, rdata;
    logic        rxie, txie, transmit_ready_flag, empty, receive_ready_flag, break_detect_flag, fe, oe, pe;
    logic        txbuf_full, txd, push, rx_par, brk_arm, samp_a, samp_b;
    logic [7:0]  rx_data, rx_hold;
    logic [15:0] baud_cnt;
    spib_rx_t    rx_st;
    logic [2:0]  rx_tick;
    logic [3:0]  rx_bit;
    logic [6:0]  brk_cnt;
    spib_tx_t    tx_st;
    logic [2:0]  tx_tick;
    logic [3:0]  tx_left;
    logic [11:0] tx_frame;
  } spib_state_t;
  spib_state_t s_r;
  spib_state_t s_nxt;
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [15:0] baud_divisor;
  logic        tick;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [14:0] idx;
  logic        swrst;
  logic        load_rx;
  logic        load_tx;
  logic        fifo_ready;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic [3:0]  nbits;
  logic        bitval;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Every access ends in its first access cycle.
  assign idx     = paddr[ADDR_W-1:2];
  assign mapped  = paddr[1:0] == 2'h0 && (idx inside {IDX_CCR, IDX_CTL1, IDX_HBAUD,
                   IDX_LBAUD, IDX_CTL2, IDX_RXST, IDX_RXEMU, IDX_RXBUF, IDX_TXBUF,
                   IDX_PC2, IDX_PRI});
  assign wr      = psel && penable && pwrite && mapped;
  assign rd      = psel && penable && !pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = {24'h0, s_r.rdata};
  assign swrst   = !s_r.ctl1[CTL1_SRSTN];
  assign baud_divisor     = {s_r.hbaud, s_r.lbaud};
  // A divisor of zero would otherwise tick every cycle; it is pinned to /16.
  // A divisor lowered below the running count must not wait for a 16-bit wrap.
  assign tick    = s_r.baud_cnt >= ((baud_divisor == 16'h0) ? ZERO_LIM : baud_divisor);
  assign nbits   = {1'b0, s_r.ccr[2:0]} + 4'h1;
  assign bitval  = (s_r.samp_a & s_r.samp_b) | (rxd & (s_r.samp_a | s_r.samp_b));
  assign load_rx = fifo_valid && !s_r.receive_ready_flag && !swrst;
  assign load_tx = s_r.tx_st == TX_IDLE && s_r.txbuf_full && s_r.ctl1[CTL1_TXENA] && !swrst;

  spib_fifo #(.W(8), .D(16)) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clr       (swrst),
    .in_valid  (s_r.push),
    .in_ready  (fifo_ready),
    .in_data   (s_r.rx_hold),
    .out_valid (fifo_valid),
    .out_ready (load_rx),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt      = s_r;
    s_nxt.push = 1'b0;
    s_nxt.baud_cnt = tick ? 16'h0 : s_r.baud_cnt + 16'h1;
    // Read data is captured in the setup cycle, so the answer is registered.
    if (psel && !penable) begin
      unique case (idx)
        IDX_CCR:   s_nxt.rdata = s_r.ccr;
        IDX_CTL1:  s_nxt.rdata = s_r.ctl1;
        IDX_HBAUD: s_nxt.rdata = s_r.hbaud;
        IDX_LBAUD: s_nxt.rdata = s_r.lbaud;
        IDX_CTL2:  s_nxt.rdata = {s_r.transmit_ready_flag, s_r.empty, 4'h0, s_r.rxie, s_r.txie};
        IDX_RXST:  s_nxt.rdata = {s_r.pe | s_r.oe | s_r.fe | s_r.break_detect_flag, s_r.receive_ready_flag,
                                  s_r.break_detect_flag, s_r.fe, s_r.oe, s_r.pe, 2'h0};
        IDX_RXEMU: s_nxt.rdata = s_r.rxbuf;
        IDX_RXBUF: s_nxt.rdata = s_r.rxbuf;
        IDX_PC2:   s_nxt.rdata = s_r.pc2;
        IDX_PRI:   s_nxt.rdata = s_r.pri;
        default:   s_nxt.rdata = 8'h0;
      endcase
    end
    if (rd && idx == IDX_RXBUF) begin
      s_nxt.receive_ready_flag = 1'b0;
    end
    if (wr) begin
      unique case (idx)
        IDX_CCR:   s_nxt.ccr = pwdata[7:0];
        IDX_CTL1:  s_nxt.ctl1 = pwdata[7:0] & CTL1_MASK;
        IDX_HBAUD: s_nxt.hbaud = pwdata[7:0];
        IDX_LBAUD: s_nxt.lbaud = pwdata[7:0];
        IDX_CTL2: begin
          s_nxt.rxie = pwdata[CTL2_RXIE];
          s_nxt.txie = pwdata[CTL2_TXIE];
        end
        IDX_PC2:   s_nxt.pc2 = pwdata[7:0];
        IDX_PRI:   s_nxt.pri = pwdata[7:0] & PRI_MASK;
        default:   s_nxt.rdata = s_r.rdata;
      endcase
    end
    // Receive buffer loads from the FIFO head.
    if (load_rx) begin
      s_nxt.rxbuf = fifo_data;
      s_nxt.receive_ready_flag = 1'b1;
    end
    // Receiver.
    if (tick) begin
      s_nxt.rx_tick = s_r.rx_tick + 3'h1;
      unique case (s_r.rx_st)
        RX_IDLE: begin
          s_nxt.rx_tick = 3'h1;
          if (!rxd && s_r.ctl1[CTL1_RXENA]) begin
            s_nxt.rx_st = RX_START;
          end
        end
        RX_START: begin
          // The start bit is judged on its first ticks and then waited out, so
          // no data sample falls inside it.
          if (rxd && s_r.rx_tick < 3'(START_TK)) begin
            s_nxt.rx_st = RX_IDLE;
          end else if (s_r.rx_tick == TICK_LAST) begin
            s_nxt.rx_st   = RX_BITS;
            s_nxt.rx_tick = 3'h0;
            s_nxt.rx_bit  = 4'h0;
            s_nxt.rx_data = 8'h0;
            s_nxt.rx_par  = 1'b0;
          end
        end
        RX_BITS: begin
          if (s_r.rx_tick == SAMP_A) s_nxt.samp_a = rxd;
          if (s_r.rx_tick == SAMP_B) s_nxt.samp_b = rxd;
          if (s_r.rx_tick == SAMP_C) begin
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
            if (s_r.rx_bit < nbits) begin
              s_nxt.rx_data[s_r.rx_bit[2:0]] = bitval;
              s_nxt.rx_par = s_r.rx_par ^ bitval;
            end else if (s_r.rx_bit == nbits && s_r.ccr[CCR_PAREN]) begin
              s_nxt.pe = s_r.pe | (s_r.rx_par ^ bitval ^ !s_r.ccr[CCR_EVEN]);
            end else begin
              // The receiver checks one stop bit only.
              s_nxt.rx_st   = RX_IDLE;
              s_nxt.fe      = s_r.fe | !bitval;
              s_nxt.brk_arm = 1'b1;
              s_nxt.push    = 1'b1;
              s_nxt.rx_hold = s_r.rx_data;
            end
          end
        end
      endcase
      // Break watch runs beside the receiver.
      // The arm survives the high stop bit; a frame's own low run is too short to trip it, except 8 zero data bits under even parity.
      if (rxd) begin
        s_nxt.brk_cnt = 7'h0;
      end else if (s_r.brk_arm) begin
        if (s_r.brk_cnt != BREAK_LIM) begin
          s_nxt.brk_cnt = s_r.brk_cnt + 7'h1;
        end else begin
          s_nxt.break_detect_flag = 1'b1;
        end
      end
    end
    // A character that finds the FIFO full is lost and flagged.
    if (s_r.push && !fifo_ready) begin
      s_nxt.oe = 1'b1;
    end
    // Transmitter.
    if (load_tx) begin
      s_nxt.tx_st    = TX_SHIFT;
      s_nxt.txbuf_full = 1'b0;
      s_nxt.transmit_ready_flag    = 1'b1;
      s_nxt.tx_tick  = 3'h0;
      s_nxt.tx_frame = 12'hfff;
      s_nxt.tx_frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(nbits)) s_nxt.tx_frame[i + 1] = s_r.txbuf[i];
      end
      if (s_r.ccr[CCR_PAREN]) begin
        s_nxt.tx_frame[nbits + 4'h1] = ^(s_r.txbuf & ~(8'hff << nbits)) ^ !s_r.ccr[CCR_EVEN];
      end
      s_nxt.tx_left = nbits + 4'h2 + {3'h0, s_r.ccr[CCR_PAREN]} + {3'h0, s_r.ccr[CCR_STOP2]};
    end else if (s_r.tx_st == TX_SHIFT && tick) begin
      s_nxt.tx_tick = s_r.tx_tick + 3'h1;
      if (s_r.tx_tick == TICK_LAST) begin
        s_nxt.tx_frame = {1'b1, s_r.tx_frame[11:1]};
        s_nxt.tx_left  = s_r.tx_left - 4'h1;
        if (s_r.tx_left == 4'h1) begin
          s_nxt.tx_st = TX_IDLE;
          s_nxt.empty = !s_r.txbuf_full;
        end
      end
    end
    s_nxt.txd = (s_nxt.tx_st == TX_SHIFT) ? s_nxt.tx_frame[0] : 1'b1;
    // A write in the load cycle refills the buffer, so the write wins there.
    if (wr && idx == IDX_TXBUF) begin
      s_nxt.txbuf      = pwdata[7:0];
      s_nxt.txbuf_full = 1'b1;
      s_nxt.transmit_ready_flag      = 1'b0;
      s_nxt.empty      = 1'b0;
    end
    // Software reset holds state machines and flags, never the configuration.
    if (swrst) begin
      s_nxt.rx_st = RX_IDLE;
      s_nxt.tx_st = TX_IDLE;
      s_nxt.txd   = 1'b1;
      s_nxt.transmit_ready_flag = 1'b1;
      s_nxt.empty = 1'b1;
      s_nxt.txbuf_full = 1'b0;
      {s_nxt.receive_ready_flag, s_nxt.break_detect_flag, s_nxt.fe, s_nxt.oe, s_nxt.pe} = 5'h0;
      {s_nxt.brk_arm, s_nxt.brk_cnt, s_nxt.push} = 9'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r       <= '0;
      s_r.transmit_ready_flag <= 1'b1;
      s_r.empty <= 1'b1;
      s_r.txd   <= 1'b1;
      s_r.ctl1  <= RST_REG;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests; priority bit set sends a request to the low level.
  assign txd          = s_r.txd;
  assign rx_irq_req   = (s_r.receive_ready_flag | s_r.break_detect_flag) & s_r.rxie;
  assign tx_irq_req   = s_r.transmit_ready_flag & s_r.txie;
  assign irq_level_hi = (rx_irq_req & !s_r.pri[PRI_RX]) | (tx_irq_req & !s_r.pri[PRI_TX]);
  assign irq_level_lo = (rx_irq_req & s_r.pri[PRI_RX]) | (tx_irq_req & s_r.pri[PRI_TX]);
  assign irq_hi_is_tx = !(rx_irq_req & !s_r.pri[PRI_RX]) & tx_irq_req & !s_r.pri[PRI_TX];
  assign irq_lo_is_tx = !(rx_irq_req & s_r.pri[PRI_RX]) & tx_irq_req & s_r.pri[PRI_TX];

  ////////////////////////////////////////////////////////////////////////////
  // Checks. The gap counter measures cycles between baud ticks.
  logic [16:0] gap_r;
  logic        brr_chg_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r     <= 17'h0;
      brr_chg_r <= 1'b1;
    end else begin
      gap_r     <= tick ? 17'h0 : gap_r + 17'h1;
      brr_chg_r <= (brr_chg_r && !tick) || baud_divisor != {s_nxt.hbaud, s_nxt.lbaud};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_baud_period: assert property (tick && !brr_chg_r && baud_divisor != 16'h0 |-> gap_r == {1'b0, baud_divisor})
    else $error("baud tick spacing wrong");
  a_baud_zero: assert property (tick && !brr_chg_r && baud_divisor == 16'h0 |-> gap_r == 17'h1)
    else $error("zero divisor tick spacing wrong");
  a_rx_irq_gate: assert property (!s_r.rxie |-> !rx_irq_req)
    else $error("receive request while disabled");
  a_tx_irq_level: assert property (s_r.transmit_ready_flag && s_r.txie |-> tx_irq_req)
    else $error("transmit request missing");
  a_rx_load_flag: assert property (load_rx |=> s_r.receive_ready_flag && s_r.rxbuf == $past(fifo_data))
    else $error("receive buffer load wrong");
  a_rxbuf_read_clear: assert property (rd && idx == IDX_RXBUF && s_r.receive_ready_flag && !swrst |=> !s_r.receive_ready_flag)
    else $error("receive-ready not cleared");
  a_txbuf_write: assert property (wr && idx == IDX_TXBUF && !swrst |=> !s_r.transmit_ready_flag && !s_r.empty)
    else $error("transmit write flags wrong");
  a_tx_load_ready: assert property (load_tx && !(wr && idx == IDX_TXBUF) |=> s_r.transmit_ready_flag)
    else $error("transmit-ready not set");
  a_brk_set: assert property (tick && s_r.brk_arm && !rxd && s_r.brk_cnt == BREAK_LIM && !swrst
    |=> s_r.break_detect_flag)
    else $error("break not flagged");
  a_same_level_rx: assert property (rx_irq_req && tx_irq_req && s_r.pri[PRI_RX] == s_r.pri[PRI_TX]
    |-> !irq_hi_is_tx && !irq_lo_is_tx)
    else $error("transmit beat receive");
  a_tx_route: assert property (tx_irq_req && !s_r.pri[PRI_TX] |-> irq_level_hi)
    else $error("transmit request misrouted");
  c_rx_load: cover property (load_rx);
  c_tx_load: cover property (load_tx);
  c_break: cover property (!s_r.break_detect_flag ##1 s_r.break_detect_flag);
  c_both_req: cover property (rx_irq_req && tx_irq_req);
endmodule
`default_nettype wire

// [sim/spib_remote.sv]
/*
  Remote serial transceiver: sends frames on the receive line and decodes
  frames seen on the transmit line. Assumes 8 data bits, no parity, one
  stop bit, and a bit time in clock cycles given by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module spib_remote (
  // Clock.
  input  wire logic        core_clk,
  // Bit time in clock cycles.
  input  wire logic [15:0] bit_cyc,
  // Serial lines.
  input  wire logic        txd,
  output var logic         rxd
);
  logic [8:0] seen_q[$];
  logic [8:0] sh;

  initial rxd = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Start bit, data least significant first, stop bit, then low_bits of low line.
  // The line goes back high afterwards, as an idle line with a pull-up would.
  task automatic send(input logic [7:0] d, input int low_bits);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10 + low_bits; i++) begin
      @(posedge core_clk);
      rxd <= (i < 10) ? f[i] : 1'b0;
      repeat (bit_cyc - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Samples mid-bit; the stop bit lands in bit 8, so a framing slip shows up.
  always begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc) @(posedge core_clk);
      sh[i] = txd;
    end
    seen_q.push_back(sh);
  end
endmodule
`default_nettype wire

// [sim/test_serial_port_irq_baud_regs.sv]
/*
  Self-checking bench for the serial port: APB master tasks, queue models
  of both directions and the remote transceiver model.
  Assumes the design files and sim/spib_remote.sv are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_irq_baud_regs;
  import spib_pkg::*;
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, perr;
  logic        rxd, txd, rx_irq_req, tx_irq_req, lv_hi, hi_tx, lv_lo, lo_tx;
  logic [16:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] bit_cyc;
  logic [7:0]  b;
  logic [7:0]  brr_tab [3] = '{8'h00, 8'h02, 8'h05};
  int          failures, samples_checked, seed, n;
  int          exp_q[$];

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  spib_top DUT (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req), .irq_level_hi(lv_hi),
    .irq_hi_is_tx(hi_tx), .irq_level_lo(lv_lo), .irq_lo_is_tx(lo_tx));
  spib_remote u_rem (.core_clk(core_clk), .bit_cyc(bit_cyc), .txd(txd), .rxd(rxd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      failures++;
    end
  endtask

  // The wait on pready is bounded so a dead slave cannot hang the run.
  task automatic apb(input logic w, input logic [14:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge core_clk);
    end
    rd      = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [14:0] idx, input logic [31:0] e, input string what);
    apb(1'b0, idx, 8'h00);
    check(what, e, rd);
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    failures++;
    complete_run;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h53d2;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 17'h00000;
    pwdata = 32'h00000000;
    bit_cyc = 16'h0010;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdchk(IDX_CTL2, 32'h000000c0, "ctl2 after reset");
    apb(1'b0, 15'h7058, 8'h00);
    check("unmapped error", 32'h1, {31'h0, perr});
    apb(1'b1, IDX_HBAUD, 8'h5a);
    apb(1'b1, IDX_LBAUD, 8'ha5);
    rdchk(IDX_HBAUD, 32'h0000005a, "baud high");
    rdchk(IDX_LBAUD, 32'h000000a5, "baud low");
    foreach (brr_tab[j]) begin
      apb(1'b1, IDX_CTL1, 8'h00);
      apb(1'b1, IDX_HBAUD, 8'h00);
      apb(1'b1, IDX_LBAUD, brr_tab[j]);
      apb(1'b1, IDX_CCR, 8'h07);
      apb(1'b1, IDX_CTL2, 8'h01);
      apb(1'b1, IDX_CTL1, 8'h23);
      bit_cyc = (brr_tab[j] == 8'h00) ? 16'h0010 : 16'(8 * (brr_tab[j] + 1));
      for (int i = 0; i < 2; i++) begin
        b = 8'($random(seed));
        exp_q.push_back({1'b1, b});
        apb(1'b1, IDX_TXBUF, b);
      end
      @(negedge core_clk);
      check("tx request while full", 32'h0, {31'h0, tx_irq_req});
      rdchk(IDX_CTL2, 32'h00000001, "ctl2 while full");
      n = 0;
      while (tx_irq_req !== 1'b1 && n < 2000) begin
        n++;
        @(posedge core_clk);
      end
      check("tx request after load", 32'h1, {31'h0, tx_irq_req});
      while (u_rem.seen_q.size() < 2 && n < 4000) begin
        n++;
        @(posedge core_clk);
      end
      while (exp_q.size() > 0 && u_rem.seen_q.size() > 0) begin
        check("tx frame", exp_q.pop_front(), {23'h0, u_rem.seen_q.pop_front()});
      end
      check("tx frames left", 32'h0, exp_q.size());
      repeat (bit_cyc) @(posedge core_clk);
      apb(1'b1, IDX_CTL2, 8'h00);
      rdchk(IDX_CTL2, 32'h000000c0, "ctl2 idle");
      b = 8'($random(seed));
      u_rem.send(b, 0);
      @(negedge core_clk);
      check("requests disabled", 32'h0, {30'h0, rx_irq_req, tx_irq_req});
      rdchk(IDX_RXST, 32'h00000040, "rx ready set");
      apb(1'b1, IDX_CTL2, 8'h03);
      for (int p = 0; p < 4; p++) begin
        apb(1'b1, IDX_PRI, {1'b0, 2'(p), 5'h00});
        @(negedge core_clk);
        check("routing", {26'h0, 2'b11, ~(p[0] & p[1]), p[0] & ~p[1], p[0] | p[1], p[1] & ~p[0]},
          {26'h0, rx_irq_req, tx_irq_req, lv_hi, hi_tx, lv_lo, lo_tx});
      end
      rdchk(IDX_RXEMU, {24'h0, b}, "rx emulation copy");
      rdchk(IDX_RXBUF, {24'h0, b}, "rx data");
      rdchk(IDX_RXST, 32'h00000000, "rx ready cleared");
      check("rx request dropped", 32'h0, {31'h0, rx_irq_req});
    end
    apb(1'b1, IDX_CTL2, 8'h00);
    for (int i = 0; i < 18; i++) begin
      b = 8'($random(seed));
      if (i < 17) exp_q.push_back(b);
      u_rem.send(b, 0);
    end
    rdchk(IDX_RXST, 32'h000000c8, "overrun status");
    while (exp_q.size() > 0) rdchk(IDX_RXBUF, exp_q.pop_front(), "fifo data");
    rdchk(IDX_RXST, 32'h00000088, "fifo drained");
    apb(1'b1, IDX_CTL1, 8'h03);
    apb(1'b1, IDX_CTL1, 8'h23);
    rdchk(IDX_RXST, 32'h00000000, "soft reset flags");
    apb(1'b1, IDX_CTL2, 8'h02);
    u_rem.send(8'h55, 12);
    apb(1'b0, IDX_RXST, 8'h00);
    check("break flag", 32'h00000020, rd & 32'h00000020);
    check("break request", 32'h1, {31'h0, rx_irq_req});
    complete_run;
  end
endmodule
`default_nettype wire
